/* iop_pkg.sv */
package iop_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PA_DATA   = 8'h00;
  localparam logic [7:0] ADDR_PA_DIR    = 8'h04;
  localparam logic [7:0] ADDR_PA_PU     = 8'h08;
  localparam logic [7:0] ADDR_PA_WAKE   = 8'h0C;
  localparam logic [7:0] ADDR_PC_DATA   = 8'h10;
  localparam logic [7:0] ADDR_PC_DIR    = 8'h14;
  localparam logic [7:0] ADDR_PC_PU     = 8'h18;
  localparam logic [7:0] ADDR_FUNC_SEL  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h24;
  localparam logic [7:0] ADDR_BIT_OP    = 8'h28;

  // ---------------------------------------------------------------
  // widths, reset values, implemented-bit masks
  // ---------------------------------------------------------------
  localparam int         PA_W         = 8;
  localparam int         PC_W         = 6;
  localparam logic [7:0] PA_DATA_RST  = 8'hFF;
  localparam logic [7:0] PA_DIR_RST   = 8'hFF;
  localparam logic [5:0] PC_DATA_RST  = 6'h3F;
  localparam logic [5:0] PC_DIR_RST   = 6'h3F;
  localparam logic [7:0] PA_PU_MASK   = 8'h7F;
  localparam logic [7:0] PA_WAKE_MASK = 8'h27;

  // function select field positions
  localparam int FS_FREQ_EN = 0;
  localparam int FS_PWM_EN  = 1;
  localparam int FS_TMR_LO  = 2;
  localparam int FS_AN_LO   = 4;
  localparam int FS_W       = 8;

  // shared pin positions
  localparam int PIN_INT   = 2;
  localparam int PIN_TMR   = 4;
  localparam int PIN_FREQ  = 3;
  localparam int PIN_PWM   = 0;
  localparam int AN_N      = 4;

  // timer modes taken from a 2-bit field
  localparam logic [1:0] TMODE_EVENT = 2'b01;
  localparam logic [1:0] TMODE_PWC   = 2'b11;

  // bit-op register fields: [2:0] bit, [3] set, [4] port c
  localparam int BOP_SET = 3;
  localparam int BOP_PC  = 4;

  // irq status bits
  localparam int IRQ_INT  = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_W    = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // pin group carrier
  typedef struct packed {
    logic [7:0] pa_out;
    logic [7:0] pa_oe;
    logic [7:0] pa_pu;
    logic [5:0] pc_out;
    logic [5:0] pc_oe;
    logic [5:0] pc_pu;
  } iop_pins_t;

endpackage : iop_pkg

/* iop_wake_det.sv */
`timescale 1ns/1ps
`default_nettype none
// clockless falling-edge catcher: the pin edge itself sets the flop
module iop_wake_det
(
  input  wire logic i_pin_b,
  input  wire logic i_en,
  input  wire logic i_clr_b,
  output logic      o_wake
);

  // ---------------------------------------------------------------
  // edge capture
  // ---------------------------------------------------------------
  // holds until the running clock domain clears it, so the wake
  // request outlives the stopped clock
  always_ff @(negedge i_pin_b or negedge i_clr_b)
  begin
    if (!i_clr_b)
      o_wake <= 1'b0;
    else
      o_wake <= i_en;
  end

endmodule : iop_wake_det
`default_nettype wire

/* iop_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - direction bit one input, zero output
// - input pin reads live level
// - output pin reads latch value
// - reset sets data and direction ones
// - new output drives reset latch high
// - port c direction top bits zero
// - bit set/clear is read-modify-write
// - interrupt from pa2 only when input
// - timer input needs mode and input
// - frequency output needs select and output
// - pwm output needs select and output
// - analog select disconnects pull-high
// - enabled pa falling edge wakes sleep
// - pull-high bits, only on inputs
// - wake enables pa0-2,5 others zero
// - inputs sampled at read, outputs latched
module iop_port
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_pa_pin,
  input  wire logic [5:0]  i_pc_pin,
  input  wire logic        i_sleep,
  input  wire logic        i_freq_src,
  input  wire logic        i_pwm_src,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output iop_pkg::iop_pins_t o_pins,
  output logic             o_ext_int,
  output logic             o_timer_in,
  output logic             o_timer_in_en,
  output logic [3:0]       o_analog_sel,
  output logic             o_wake,
  output logic             o_irq
);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic       rst_m_ff;
  logic       rst_ff;
  logic [7:0] pa_m_ff;
  logic [7:0] pa_s_ff;
  logic [7:0] pa_d_ff;
  logic [5:0] pc_m_ff;
  logic [5:0] pc_s_ff;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_m_ff <= 1'b0;
      rst_ff   <= 1'b0;
    end
    else
    begin
      rst_m_ff <= 1'b1;
      rst_ff   <= rst_m_ff;
    end
  end

  always_ff @(posedge i_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      pa_m_ff <= 8'hFF;
      pa_s_ff <= 8'hFF;
      pa_d_ff <= 8'hFF;
      pc_m_ff <= 6'h3F;
      pc_s_ff <= 6'h3F;
    end
    else
    begin
      pa_m_ff <= i_pa_pin;
      pa_s_ff <= pa_m_ff;
      pa_d_ff <= pa_s_ff;
      pc_m_ff <= i_pc_pin;
      pc_s_ff <= pc_m_ff;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] pa_data_ff;
  logic [7:0] pa_dir_ff;
  logic [7:0] pa_pu_ff;
  logic [7:0] pa_wake_ff;
  logic [5:0] pc_data_ff;
  logic [5:0] pc_dir_ff;
  logic [5:0] pc_pu_ff;
  logic [7:0] fsel_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;

  logic        aw_ff;
  logic        aw_hi_ff;
  logic        w_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        wstrb0_ff;
  logic        do_wr;

  // pin view: input reads live pin, output reads the latch
  logic [7:0] pa_view;
  logic [5:0] pc_view;
  assign pa_view = (pa_dir_ff & pa_s_ff) | (~pa_dir_ff & pa_data_ff);
  assign pc_view = (pc_dir_ff & pc_s_ff) | (~pc_dir_ff & pc_data_ff);

  // bit-op: read whole port, change one bit, write whole port back
  logic [7:0] bop_byte;
  logic [7:0] bop_mask;
  logic       bop_set;
  logic       bop_pc;
  assign bop_mask = 8'h01 << wdata_ff[2:0];
  assign bop_set  = wdata_ff[iop_pkg::BOP_SET];
  assign bop_pc   = wdata_ff[iop_pkg::BOP_PC];
  assign bop_byte = bop_set ?
    ((bop_pc ? {2'b00, pc_view} : pa_view) | bop_mask) :
    ((bop_pc ? {2'b00, pc_view} : pa_view) & ~bop_mask);

  logic wr_en;
  // an address above the map must not alias onto a register
  assign wr_en = do_wr & wstrb0_ff & !aw_hi_ff;

  always_ff @(posedge i_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      pa_data_ff <= iop_pkg::PA_DATA_RST;
      pa_dir_ff  <= iop_pkg::PA_DIR_RST;
      pc_data_ff <= iop_pkg::PC_DATA_RST;
      pc_dir_ff  <= iop_pkg::PC_DIR_RST;
      pa_pu_ff   <= 8'h00;
      pa_wake_ff <= 8'h00;
      pc_pu_ff   <= 6'h00;
      fsel_ff    <= 8'h00;
      mask_ff    <= 2'b00;
    end
    else if (wr_en)
    begin
      case (awaddr_ff)
        iop_pkg::ADDR_PA_DATA: pa_data_ff <= wdata_ff[7:0];
        iop_pkg::ADDR_PA_DIR:  pa_dir_ff  <= wdata_ff[7:0];
        iop_pkg::ADDR_PA_PU:
          pa_pu_ff <= wdata_ff[7:0] & iop_pkg::PA_PU_MASK;
        iop_pkg::ADDR_PA_WAKE:
          pa_wake_ff <= wdata_ff[7:0] & iop_pkg::PA_WAKE_MASK;
        iop_pkg::ADDR_PC_DATA: pc_data_ff <= wdata_ff[5:0];
        iop_pkg::ADDR_PC_DIR:  pc_dir_ff  <= wdata_ff[5:0];
        iop_pkg::ADDR_PC_PU:   pc_pu_ff   <= wdata_ff[5:0];
        iop_pkg::ADDR_FUNC_SEL: fsel_ff   <= wdata_ff[7:0];
        iop_pkg::ADDR_IRQ_MASK: mask_ff   <= wdata_ff[1:0];
        iop_pkg::ADDR_BIT_OP:
        begin
          if (bop_pc)
            pc_data_ff <= bop_byte[5:0];
          else
            pa_data_ff <= bop_byte;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign do_wr = aw_ff & w_ff & !s_axi_bvalid;

  always_ff @(posedge i_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      awaddr_ff    <= 8'h00;
      aw_hi_ff     <= 1'b0;
      wdata_ff     <= 32'h0000_0000;
      wstrb0_ff    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= iop_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr[7:0];
        aw_hi_ff  <= |s_axi_awaddr[31:8];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff      <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (do_wr)
      begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff > iop_pkg::ADDR_BIT_OP ||
                         awaddr_ff[1:0] != 2'b00 ||
                         aw_hi_ff) ?
                        iop_pkg::RESP_SLVERR : iop_pkg::RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    s_axi_awready = !aw_ff && !s_axi_bvalid;
    s_axi_wready  = !w_ff && !s_axi_bvalid;
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_bad;

  always_comb
  begin
    rd_bad = 1'b0;
    case (s_axi_araddr[7:0])
      iop_pkg::ADDR_PA_DATA:  rd_mux = {24'h00_0000, pa_view};
      iop_pkg::ADDR_PA_DIR:   rd_mux = {24'h00_0000, pa_dir_ff};
      iop_pkg::ADDR_PA_PU:    rd_mux = {24'h00_0000, pa_pu_ff};
      iop_pkg::ADDR_PA_WAKE:  rd_mux = {24'h00_0000, pa_wake_ff};
      iop_pkg::ADDR_PC_DATA:  rd_mux = {26'h000_0000, pc_view};
      iop_pkg::ADDR_PC_DIR:   rd_mux = {26'h000_0000, pc_dir_ff};
      iop_pkg::ADDR_PC_PU:    rd_mux = {26'h000_0000, pc_pu_ff};
      iop_pkg::ADDR_FUNC_SEL: rd_mux = {24'h00_0000, fsel_ff};
      iop_pkg::ADDR_IRQ_STAT: rd_mux = {30'h0000_0000, stat_ff};
      iop_pkg::ADDR_IRQ_MASK: rd_mux = {30'h0000_0000, mask_ff};
      iop_pkg::ADDR_BIT_OP:   rd_mux = 32'h0000_0000;
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b1;
      end
    endcase
    if (s_axi_araddr[31:8] != 24'h00_0000)
      rd_bad = 1'b1;
  end

  always_ff @(posedge i_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= iop_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_bad ? iop_pkg::RESP_SLVERR : iop_pkg::RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  // ---------------------------------------------------------------
  // pin drive and shared functions
  // ---------------------------------------------------------------
  logic       freq_on;
  logic       pwm_on;
  logic [7:0] pa_drv;
  logic [7:0] an_pa;
  assign freq_on = fsel_ff[iop_pkg::FS_FREQ_EN] &
                   !pa_dir_ff[iop_pkg::PIN_FREQ];
  assign pwm_on  = fsel_ff[iop_pkg::FS_PWM_EN] &
                   !pa_dir_ff[iop_pkg::PIN_PWM];
  assign an_pa   = {4'h0, fsel_ff[iop_pkg::FS_AN_LO +: iop_pkg::AN_N]};

  genvar gi;
  generate
    for (gi = 0; gi < iop_pkg::PA_W; gi++)
    begin : g_pa
      assign pa_drv[gi] =
        (gi == iop_pkg::PIN_FREQ && freq_on) ? i_freq_src :
        (gi == iop_pkg::PIN_PWM  && pwm_on)  ? i_pwm_src  :
        pa_data_ff[gi];
    end
  endgenerate

  always_ff @(posedge i_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      o_pins       <= '{pa_out: 8'hFF, pa_oe: 8'h00, pa_pu: 8'h00,
                        pc_out: 6'h3F, pc_oe: 6'h00, pc_pu: 6'h00};
      o_analog_sel <= 4'h0;
    end
    else
    begin
      o_pins.pa_out <= pa_drv;
      o_pins.pa_oe  <= ~pa_dir_ff;
      o_pins.pa_pu  <= pa_pu_ff & pa_dir_ff &
                       iop_pkg::PA_PU_MASK & ~an_pa;
      o_pins.pc_out <= pc_data_ff;
      o_pins.pc_oe  <= ~pc_dir_ff;
      o_pins.pc_pu  <= pc_pu_ff & pc_dir_ff;
      o_analog_sel  <= fsel_ff[iop_pkg::FS_AN_LO +: iop_pkg::AN_N];
    end
  end

  // ---------------------------------------------------------------
  // interrupt, timer input, wake
  // ---------------------------------------------------------------
  logic       tmr_mode_ok;
  logic       int_fall;
  logic [7:0] wk_raw;
  logic       wk_any;
  logic       wk_m_ff;
  logic       wk_s_ff;
  assign tmr_mode_ok =
    fsel_ff[iop_pkg::FS_TMR_LO +: 2] == iop_pkg::TMODE_EVENT ||
    fsel_ff[iop_pkg::FS_TMR_LO +: 2] == iop_pkg::TMODE_PWC;
  assign int_fall = pa_dir_ff[iop_pkg::PIN_INT] &
                    pa_d_ff[iop_pkg::PIN_INT] & !pa_s_ff[iop_pkg::PIN_INT];

  generate
    for (gi = 0; gi < iop_pkg::PA_W; gi++)
    begin : g_wk
      if (iop_pkg::PA_WAKE_MASK[gi])
      begin : g_on
        iop_wake_det u_det
        (
          .i_pin_b (i_pa_pin[gi]),
          .i_en    (pa_wake_ff[gi] & i_sleep),
          .i_clr_b (rst_ff & i_sleep),
          .o_wake  (wk_raw[gi])
        );
      end
      else
      begin : g_off
        assign wk_raw[gi] = 1'b0;
      end
    end
  endgenerate
  assign wk_any = |wk_raw;

  always_ff @(posedge i_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      wk_m_ff       <= 1'b0;
      wk_s_ff       <= 1'b0;
      o_wake        <= 1'b0;
      o_ext_int     <= 1'b1;
      o_timer_in    <= 1'b1;
      o_timer_in_en <= 1'b0;
      stat_ff       <= 2'b00;
      o_irq         <= 1'b0;
    end
    else
    begin
      wk_m_ff       <= wk_any;
      wk_s_ff       <= wk_m_ff;
      o_wake        <= wk_s_ff;
      o_ext_int     <= pa_dir_ff[iop_pkg::PIN_INT] ?
                       pa_s_ff[iop_pkg::PIN_INT] : 1'b1;
      o_timer_in_en <= tmr_mode_ok & pa_dir_ff[iop_pkg::PIN_TMR];
      o_timer_in    <= (tmr_mode_ok & pa_dir_ff[iop_pkg::PIN_TMR]) ?
                       pa_s_ff[iop_pkg::PIN_TMR] : 1'b1;
      // set beats the write-one clear
      stat_ff[iop_pkg::IRQ_INT] <= int_fall |
        (stat_ff[iop_pkg::IRQ_INT] &
         !(wr_en && awaddr_ff == iop_pkg::ADDR_IRQ_STAT &&
           wdata_ff[iop_pkg::IRQ_INT]));
      stat_ff[iop_pkg::IRQ_WAKE] <= wk_s_ff |
        (stat_ff[iop_pkg::IRQ_WAKE] &
         !(wr_en && awaddr_ff == iop_pkg::ADDR_IRQ_STAT &&
           wdata_ff[iop_pkg::IRQ_WAKE]));
      o_irq <= |(stat_ff & mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_ff);

  out_enable_a: assert property (##1 o_pins.pa_oe == ~$past(pa_dir_ff))
    else $error("pa output enable not inverse of direction");
  pc_dir_top_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == {24'h00_0000, iop_pkg::ADDR_PC_DIR} |=>
      s_axi_rdata[7:6] == 2'b00)
    else $error("pc direction top bits not zero");
  read_view_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == {24'h00_0000, iop_pkg::ADDR_PA_DATA} |=>
      ((s_axi_rdata[7:0] ^ $past(pa_data_ff)) & ~$past(pa_dir_ff)) == 8'h00
      && ((s_axi_rdata[7:0] ^ $past(pa_s_ff)) & $past(pa_dir_ff)) == 8'h00)
    else $error("port a read view wrong");
  pu_input_a: assert property (##1 (o_pins.pa_pu & o_pins.pa_oe) == 8'h00)
    else $error("pull-high on output pin");
  wake_mask_a: assert property ((pa_wake_ff & ~iop_pkg::PA_WAKE_MASK) == 8'h00)
    else $error("unimplemented wake bit set");
  ext_int_a: assert property (!pa_dir_ff[iop_pkg::PIN_INT] |=> o_ext_int)
    else $error("interrupt fed from output pin");
  timer_gate_a: assert property (o_timer_in_en |->
      $past(pa_dir_ff[iop_pkg::PIN_TMR]) && $past(tmr_mode_ok))
    else $error("timer input enabled wrongly");
  freq_gate_a: assert property (pa_dir_ff[iop_pkg::PIN_FREQ] |=>
      o_pins.pa_oe[iop_pkg::PIN_FREQ] == 1'b0)
    else $error("frequency pin driven while input");
  bit_op_a: assert property (wr_en && awaddr_ff == iop_pkg::ADDR_BIT_OP &&
      !bop_pc |=> pa_data_ff == $past(bop_byte))
    else $error("bit op writeback wrong");

endmodule : iop_port
`default_nettype wire

/* iop_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iop_pin_model
(
  input  wire logic               i_clk,
  input  wire iop_pkg::iop_pins_t i_pins,
  input  wire logic [7:0]         i_pa_drv,
  input  wire logic [7:0]         i_pa_den,
  input  wire logic [5:0]         i_pc_drv,
  input  wire logic [5:0]         i_pc_den,
  output logic [7:0]              o_pa_pin,
  output logic [5:0]              o_pc_pin
);
  // ---------------------------------------------------------------
  // pin level resolution
  // ---------------------------------------------------------------
  // a pin nobody drives and nothing pulls up toggles every cycle,
  // so a stale level can never pass for a real one
  logic float_ff = 1'b0;

  always @(posedge i_clk) float_ff <= ~float_ff;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      o_pa_pin[i] = i_pins.pa_oe[i] ? i_pins.pa_out[i] :
                    i_pa_den[i] ? i_pa_drv[i] :
                    i_pins.pa_pu[i] ? 1'b1 : float_ff;
    for (int i = 0; i < 6; i++)
      o_pc_pin[i] = i_pins.pc_oe[i] ? i_pins.pc_out[i] :
                    i_pc_den[i] ? i_pc_drv[i] :
                    i_pins.pc_pu[i] ? 1'b1 : float_ff;
  end
endmodule : iop_pin_model
`default_nettype wire

/* iop_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module iop_port_tb;
  logic               i_clk = 1'b0;
  logic               i_rst_b = 1'b0;
  logic               clk_run = 1'b1;
  logic [7:0]         i_pa_pin;
  logic [5:0]         i_pc_pin;
  logic               i_sleep = 1'b0;
  logic               i_freq_src = 1'b0;
  logic               i_pwm_src = 1'b0;
  logic [31:0]        s_axi_awaddr = '0;
  logic [31:0]        s_axi_wdata = '0;
  logic [31:0]        s_axi_araddr = '0;
  logic [31:0]        s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
  logic               o_ext_int, o_timer_in, o_timer_in_en, o_wake, o_irq;
  logic [3:0]         o_analog_sel;
  iop_pkg::iop_pins_t o_pins;
  logic [7:0]         pa_drv = 8'hFF;
  logic [5:0]         pc_drv = 6'h3F;
  logic [31:0]        seed = 32'h0000_5727;
  logic [31:0]        rv, d, v, e;
  int                 n_errors = 0;
  int                 total_checks = 0;

  always #10 i_clk = clk_run ? ~i_clk : i_clk;

  iop_port dut (.i_clk, .i_rst_b, .i_pa_pin, .i_pc_pin, .i_sleep,
    .i_freq_src, .i_pwm_src, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_pins, .o_ext_int,
    .o_timer_in, .o_timer_in_en, .o_analog_sel, .o_wake, .o_irq);

  iop_pin_model pins (.i_clk, .i_pins(o_pins), .i_pa_drv(pa_drv),
    .i_pa_den(8'hFF), .i_pc_drv(pc_drv), .i_pc_den(6'h3F),
    .o_pa_pin(i_pa_pin), .o_pc_pin(i_pc_pin));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 100)
    begin
      @(posedge i_clk);
      n++;
      aw_ok = aw_ok | (s_axi_awready === 1'b1);
      w_ok = w_ok | (s_axi_wready === 1'b1);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200)
    begin
      @(posedge i_clk);
      n++;
    end
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (n >= 200) n_errors++;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 200) n_errors++;
    @(posedge i_clk);
  endtask : rd

  task automatic chk_rd(input string nm, input logic [7:0] a,
                        input logic [31:0] x);
    rd(a);
    `CHK(nm, x, rv)
  endtask : chk_rd

  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #1_000_000;
    n_errors++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    tick(8);
    i_rst_b <= 1'b1;
    tick(3);
    chk_rd("pa_dir", iop_pkg::ADDR_PA_DIR, 32'h0000_00FF);
    chk_rd("pc_dir", iop_pkg::ADDR_PC_DIR, 32'h0000_003F);
    chk_rd("pa_wake", iop_pkg::ADDR_PA_WAKE, 32'h0000_0000);
    `CHK("oe_rst", 8'h00, o_pins.pa_oe)
    wr(iop_pkg::ADDR_PC_DIR, 32'h0000_00C0);
    chk_rd("pc_dir_top", iop_pkg::ADDR_PC_DIR, 32'h0000_0000);
    // outputs switched on before any data write
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_0000);
    tick(2);
    `CHK("pa_oe", 8'hFF, o_pins.pa_oe)
    `CHK("pa_out", 8'hFF, o_pins.pa_out)
    `CHK("pc_out", 6'h3F, o_pins.pc_out)
    for (int i = 0; i < 12; i++)
    begin
      d = rnd();
      v = rnd();
      e = rnd();
      wr(iop_pkg::ADDR_PA_DATA, v);
      wr(iop_pkg::ADDR_PA_DIR, d);
      wr(iop_pkg::ADDR_PC_DATA, e);
      wr(iop_pkg::ADDR_PC_DIR, v);
      pa_drv <= e[15:8];
      pc_drv <= d[13:8];
      tick(3);
      rd(iop_pkg::ADDR_PA_DATA);
      `CHK("pa_rd", {24'h0, d[7:0] & e[15:8] | ~d[7:0] & v[7:0]}, rv)
      rd(iop_pkg::ADDR_PC_DATA);
      `CHK("pc_rd", {26'h0, v[5:0] & d[13:8] | ~v[5:0] & e[5:0]}, rv)
      `CHK("oe_rnd", ~d[7:0], o_pins.pa_oe)
    end
    // pull-ups gated by direction and analog select
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_000F);
    wr(iop_pkg::ADDR_PA_PU, 32'h0000_00FF);
    chk_rd("pa_pu", iop_pkg::ADDR_PA_PU, 32'h0000_007F);
    wr(iop_pkg::ADDR_FUNC_SEL, 32'h0000_0050);
    tick(2);
    `CHK("pu_pins", 8'h0A, o_pins.pa_pu)
    `CHK("an_sel", 4'h5, o_analog_sel)
    wr(iop_pkg::ADDR_PA_WAKE, 32'h0000_00FF);
    chk_rd("wake_en", iop_pkg::ADDR_PA_WAKE, 32'h0000_0027);
    // bit set on port a, bit clear on port c: inputs fold their pin level into the latch
    wr(iop_pkg::ADDR_FUNC_SEL, 32'h0000_0000);
    wr(iop_pkg::ADDR_PA_DATA, 32'h0000_0000);
    wr(iop_pkg::ADDR_PC_DIR, 32'h0000_003F);
    pa_drv <= 8'h0A;
    pc_drv <= 6'h15;
    tick(3);
    wr(iop_pkg::ADDR_BIT_OP, 32'h0000_000F);
    wr(iop_pkg::ADDR_BIT_OP, 32'h0000_0010);
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_0000);
    wr(iop_pkg::ADDR_PC_DIR, 32'h0000_0000);
    tick(2);
    `CHK("bop_set", 8'h8A, o_pins.pa_out)
    `CHK("bop_clr", 6'h14, o_pins.pc_out)
    // timer input gating over every mode and both directions
    pa_drv <= 8'hEF;
    for (int m = 0; m < 8; m++)
    begin
      wr(iop_pkg::ADDR_FUNC_SEL, {28'h0, m[1:0], 2'b00});
      wr(iop_pkg::ADDR_PA_DIR, m[2] ? 32'h0000_00FF : 32'h0000_00EF);
      tick(3);
      `CHK("tmr_en", m[0] & m[2], o_timer_in_en)
      `CHK("tmr_in", ~(m[0] & m[2]), o_timer_in)
    end
    // frequency and pwm outputs, latch still read back
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_00F6);
    wr(iop_pkg::ADDR_PA_DATA, 32'h0000_00FF);
    wr(iop_pkg::ADDR_FUNC_SEL, 32'h0000_0003);
    tick(3);
    `CHK("freq_out", 1'b0, o_pins.pa_out[3])
    `CHK("pwm_out", 1'b0, o_pins.pa_out[0])
    chk_rd("latch_rd", iop_pkg::ADDR_PA_DATA, 32'h0000_00EF);
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_00FF);
    tick(2);
    `CHK("fn_in_oe", 8'h00, o_pins.pa_oe)
    `CHK("fn_in_pu", 8'h7F, o_pins.pa_pu)
    // external interrupt: raise, mask, clear
    wr(iop_pkg::ADDR_FUNC_SEL, 32'h0000_0000);
    pa_drv <= 8'hFF;
    tick(4);
    wr(iop_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    wr(iop_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    pa_drv <= 8'hFB;
    tick(5);
    `CHK("ext_int", 1'b0, o_ext_int)
    `CHK("irq_on", 1'b1, o_irq)
    chk_rd("stat_int", iop_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    wr(iop_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    tick(2);
    `CHK("irq_mask", 1'b0, o_irq)
    wr(iop_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    chk_rd("stat_clr", iop_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // a falling edge while the pin is an output is not an interrupt
    pa_drv <= 8'hFF;
    wr(iop_pkg::ADDR_PA_DATA, 32'h0000_00FB);
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_00FB);
    tick(5);
    `CHK("int_out", 1'b1, o_ext_int)
    chk_rd("stat_out", iop_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // wake from sleep with the clock stopped
    wr(iop_pkg::ADDR_PA_DIR, 32'h0000_00FF);
    wr(iop_pkg::ADDR_PA_WAKE, 32'h0000_0020);
    i_sleep <= 1'b1;
    tick(4);
    pa_drv <= 8'hFE;
    tick(4);
    `CHK("wake_off", 1'b0, o_wake)
    clk_run = 1'b0;
    #200;
    pa_drv = 8'hDE;
    #200;
    clk_run = 1'b1;
    tick(4);
    `CHK("wake_on", 1'b1, o_wake)
    chk_rd("stat_wake", iop_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    i_sleep <= 1'b0;
    tick(4);
    `CHK("wake_clr", 1'b0, o_wake)
    // unmapped place
    rd(8'h2C);
    `CHK("rd_err", iop_pkg::RESP_SLVERR, resp)
    `CHK("rd_zero", 32'h0000_0000, rv)
    wr(8'h30, 32'h0000_00FF);
    `CHK("wr_err", iop_pkg::RESP_SLVERR, resp)
    complete_run();
  end
endmodule : iop_port_tb
`default_nettype wire
